// ==== asr_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - Write holds chip select and write strobe low; output drive stays high.
// - Read lowers chip select and output drive with write strobe high.
// - Write data and address held stable past the ending edge.
// - Host drives data only after output drive high and turnaround.
// - Address set up before any select goes low.
module asr_ctrl (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // User request
    input wire logic req_valid_in,
    input wire asr_pkg::asr_req_s req_in,
    output logic req_ready_out,
    // User answer
    output logic rd_valid_out,
    output logic [asr_pkg::DATA_W-1:0] rd_data_out,
    output logic wr_done_out,
    // Memory pins
    output asr_pkg::asr_pins_s pins_out,
    output logic [asr_pkg::ADDR_W-1:0] address_pins_out,
    input wire logic [asr_pkg::DATA_W-1:0] data_pins_in,
    output logic [asr_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_n_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_READ, ST_WRITE, ST_WEND, ST_TURN
    } asr_state_e;

    asr_state_e state_reg;
    asr_pkg::asr_req_s cur_reg;
    logic cnt_load;
    logic [asr_pkg::CNT_W-1:0] cnt_value;
    logic cnt_done;

    // Lane mask from byte enables
    function automatic logic [asr_pkg::DATA_W-1:0] lane_mask(
        input logic [1:0] en);
        lane_mask = {{asr_pkg::BYTE_W{en[1]}}, {asr_pkg::BYTE_W{en[0]}}};
    endfunction

    asr_cnt #(.W(asr_pkg::CNT_W)) u_cnt (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .load_in(cnt_load),
        .value_in(cnt_value),
        .done_out(cnt_done)
    );

    // Phase timer loads
    always_comb begin
        cnt_load = 1'b0;
        cnt_value = '0;
        case (state_reg)
            ST_SETUP: begin
                cnt_load = 1'b1;
                cnt_value = cur_reg.write ?
                    asr_pkg::CNT_W'(asr_pkg::WE_CYC) :
                    asr_pkg::CNT_W'(asr_pkg::RD_CYC);
            end
            ST_WEND, ST_READ: begin
                if (cnt_done) begin
                    cnt_load = 1'b1;
                    cnt_value = asr_pkg::CNT_W'(asr_pkg::HZ_CYC);
                end
            end
            default: ;
        endcase
    end

    // Sequencer
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: if (req_valid_in) state_reg <= ST_SETUP;
                ST_SETUP: state_reg <= cur_reg.write ? ST_WRITE : ST_READ;
                ST_WRITE: if (cnt_done) state_reg <= ST_WEND;
                ST_WEND: state_reg <= ST_IDLE;
                ST_READ: if (cnt_done) state_reg <= ST_TURN;
                ST_TURN: if (cnt_done) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Request latch, held through the whole access
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cur_reg <= '0;
        end else if (state_reg == ST_IDLE && req_valid_in) begin
            cur_reg <= req_in;
        end
    end

    // Ready only in idle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= (state_reg == ST_IDLE) && !req_valid_in;
        end
    end

    // Address pins follow the latched request
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            address_pins_out <= '0;
        end else if (state_reg == ST_IDLE && req_valid_in) begin
            address_pins_out <= req_in.addr;
        end
    end

    // Strobes, set up one cycle after address
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pins_out <= {5{asr_pkg::STROBE_IDLE}};
        end else begin
            case (state_reg)
                ST_SETUP: begin
                    pins_out.chip_sel_n <= 1'b0;
                    pins_out.write_n <= !cur_reg.write;
                    pins_out.out_drive_n <= cur_reg.write;
                    pins_out.upper_byte_sel_n <= !cur_reg.byte_en[1];
                    pins_out.lower_byte_sel_n <= !cur_reg.byte_en[0];
                end
                ST_WRITE: if (cnt_done) pins_out.write_n <= 1'b1;
                ST_READ: if (cnt_done) pins_out <= {5{asr_pkg::STROBE_IDLE}};
                default: pins_out <= {5{asr_pkg::STROBE_IDLE}};
            endcase
        end
    end

    // Data drive only during writes
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            data_pins_out <= '0;
            data_pins_oe_n_out <= 1'b1;
        end else if (state_reg == ST_SETUP && cur_reg.write) begin
            data_pins_out <= cur_reg.wdata;
            data_pins_oe_n_out <= 1'b0;
        end else if (state_reg == ST_WEND || state_reg == ST_IDLE) begin
            data_pins_oe_n_out <= 1'b1;
        end
    end

    // Read capture at end of read phase
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
        end else begin
            rd_valid_out <= (state_reg == ST_READ) && cnt_done;
            if (state_reg == ST_READ && cnt_done) begin
                rd_data_out <= data_pins_in & lane_mask(cur_reg.byte_en);
            end
        end
    end

    // Write completion pulse
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_done_out <= 1'b0;
        end else begin
            wr_done_out <= (state_reg == ST_WEND);
        end
    end

    // Checks
    sequence s_wr_end;
        !pins_out.write_n ##1 pins_out.write_n && !pins_out.chip_sel_n;
    endsequence

    a_oe_during_write: assert property (@(posedge mclk_in)
        disable iff (rst_in) !pins_out.write_n |-> pins_out.out_drive_n)
        else $error("output drive low during write");
    a_no_drive_read: assert property (@(posedge mclk_in)
        disable iff (rst_in) !pins_out.out_drive_n |-> data_pins_oe_n_out)
        else $error("host drives data during read");
    a_cs_after_we: assert property (@(posedge mclk_in)
        disable iff (rst_in) s_wr_end |=> pins_out.chip_sel_n)
        else $error("chip select not released after write");
    a_data_hold: assert property (@(posedge mclk_in)
        disable iff (rst_in) s_wr_end |-> !data_pins_oe_n_out)
        else $error("write data dropped before write end");
    a_addr_stable: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        !pins_out.chip_sel_n |-> $stable(address_pins_out))
        else $error("address moved while selected");
    a_we_width: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        $fell(pins_out.write_n) |-> !pins_out.write_n [*5])
        else $error("write strobe too short");
    // Data is registered one edge after the last read cycle
    a_read_width: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        $fell(pins_out.out_drive_n) |-> ##8 rd_valid_out)
        else $error("read data not captured on time");
    a_idle_standby: assert property (@(posedge mclk_in)
        disable iff (rst_in) state_reg == ST_IDLE |-> pins_out.chip_sel_n)
        else $error("chip selected while idle");
    a_we_in_sel: assert property (@(posedge mclk_in)
        disable iff (rst_in) !pins_out.write_n |-> !pins_out.chip_sel_n)
        else $error("write strobe low without chip select");
    a_addr_setup: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        $fell(pins_out.chip_sel_n) |-> $stable(address_pins_out))
        else $error("address changed as chip select fell");
    // Memory needs time to release the bus after a read
    a_turn_gap: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        $rose(pins_out.out_drive_n) |-> data_pins_oe_n_out [*3])
        else $error("host drove data too soon after a read");
endmodule // asr_ctrl

// ==== asr_pkg.sv ====
package asr_pkg;
    // Geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    // Timing, ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RC_NS = 70;   // read cycle and address to data valid
    localparam int T_WC_NS = 70;   // write cycle
    localparam int T_PWE_NS = 50;  // write strobe pulse width
    localparam int T_SD_NS = 30;   // data setup to write end
    localparam int T_HZ_NS = 25;   // output to high impedance
    // Cycle counts, least times rounded up
    localparam int RD_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYC = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // Reset values of the strobes, all inactive
    localparam logic STROBE_IDLE = 1'b1;

    // Request from the user side
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] byte_en;   // bit 1 upper lane, bit 0 lower lane
    } asr_req_s;

    // Strobes toward the memory, all active low
    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_drive_n;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
    } asr_pins_s;
endpackage

// ==== asr_cnt.sv ====
`timescale 1ns/1ps
// Down counter that marks when a programmed phase length has elapsed
module asr_cnt #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Control
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    // Status
    output logic done_out
);
    logic [W-1:0] count_reg;

    // Count down to zero after a load
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= value_in;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Flag stands one cycle as the count reaches zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= !load_in && (count_reg == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule // asr_cnt

// ==== asr_mem_model.sv ====
`timescale 1ns/1ps
// Behavioural static memory on the far side of the controller
module asr_mem_model (
    // Clock for the released-bus pattern
    input wire logic mclk_in,
    // Memory pins
    input wire asr_pkg::asr_pins_s pins_in,
    input wire logic [16:0] address_pins_in,
    input wire logic [15:0] host_data_in,
    input wire logic host_oe_n_in,
    // Resolved data bus and contention flag
    output logic [15:0] bus_out,
    output logic clash_out
);
    logic [15:0] mem [131072];
    logic [15:0] junk = 16'h3c5a;
    logic [1:0] lane_n;
    logic sel, wr, rd;

    // Decode of the strobes
    assign lane_n = {pins_in.upper_byte_sel_n, pins_in.lower_byte_sel_n};
    assign sel = !pins_in.chip_sel_n && lane_n != 2'b11;
    assign wr = sel && !pins_in.write_n;
    assign rd = sel && pins_in.write_n && !pins_in.out_drive_n;
    assign clash_out = rd && !host_oe_n_in;

    // Memory starts cleared so unwritten words read zero
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 16'h0000;
    end

    // Floating bus shows a new pattern every cycle
    always @(posedge mclk_in) junk <= junk + 16'h9e37;

    // Selected lanes follow the data until the overlap ends
    always @* begin
        if (wr) begin
            if (!lane_n[0]) mem[address_pins_in][7:0] = host_data_in[7:0];
            if (!lane_n[1]) mem[address_pins_in][15:8] = host_data_in[15:8];
        end
    end

    // Each lane: memory read, else host drive, else floating
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (rd && !lane_n[i])
                bus_out[i*8+:8] = mem[address_pins_in][i*8+:8];
            else if (!host_oe_n_in)
                bus_out[i*8+:8] = host_data_in[i*8+:8];
            else
                bus_out[i*8+:8] = junk[i*8+:8];
        end
    end
endmodule // asr_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the memory controller
module tb_top;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    asr_pkg::asr_req_s req_in = '0;
    logic req_ready_out, rd_valid_out, wr_done_out, data_pins_oe_n_out, clash;
    logic [15:0] rd_data_out, data_pins_out, bus;
    logic [16:0] address_pins_out;
    asr_pkg::asr_pins_s pins_out;
    logic [15:0] sb [131072];
    int bad_count = 0;
    int comparisons = 0;
    int seed = 32'h545e;

    // Clock, 10 ns period
    always #5 mclk_in = ~mclk_in;

    asr_ctrl dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .wr_done_out(wr_done_out),
        .pins_out(pins_out), .address_pins_out(address_pins_out),
        .data_pins_in(bus), .data_pins_out(data_pins_out),
        .data_pins_oe_n_out(data_pins_oe_n_out));

    asr_mem_model mem (.mclk_in(mclk_in), .pins_in(pins_out),
        .address_pins_in(address_pins_out), .host_data_in(data_pins_out),
        .host_oe_n_in(data_pins_oe_n_out), .bus_out(bus), .clash_out(clash));

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bits of the word that the byte enables select
    function automatic logic [15:0] lane_bits(input logic [1:0] en);
        lane_bits = {{8{en[1]}}, {8{en[0]}}};
    endfunction

    // One request; waits for its answer and checks read data
    task automatic access(input logic w, input logic [16:0] a,
                          input logic [15:0] d, input logic [1:0] en);
        logic [15:0] m;
        int n;
        m = lane_bits(en);
        n = 0;
        while (req_ready_out !== 1'b1 && n < 20) begin
            @(negedge mclk_in);
            n++;
        end
        check({15'h0, req_ready_out}, 16'h0001);
        req_in.write = w;
        req_in.addr = a;
        req_in.wdata = d;
        req_in.byte_en = en;
        req_valid_in = 1'b1;
        @(negedge mclk_in);
        req_valid_in = 1'b0;
        n = 0;
        while (!(rd_valid_out === 1'b1 || wr_done_out === 1'b1) && n < 20) begin
            @(negedge mclk_in);
            n++;
        end
        check({14'h0, rd_valid_out, wr_done_out}, {14'h0, !w, w});
        if (w) sb[a] = (sb[a] & ~m) | (d & m);
        else check(rd_data_out, sb[a] & m);
    endtask

    // Both sides must never drive the bus together
    always @(negedge mclk_in) begin
        if (clash === 1'b1) begin
            bad_count++;
            $display("ERROR t=%0t clash %h %h", $time, bus, data_pins_out);
        end
    end

    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected run
    initial begin
        #100000;
        bad_count++;
        $display("ERROR t=%0t watchdog %h %h", $time, comparisons, 0);
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] r, d;
        logic [16:0] a;
        for (int i = 0; i < 131072; i++) sb[i] = 16'h0000;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 1'b0;
        // Reset in the middle of a write returns every strobe to idle
        req_in.write = 1'b1;
        req_in.addr = 17'h00010;
        req_in.wdata = 16'hbeef;
        req_in.byte_en = 2'b11;
        req_valid_in = 1'b1;
        @(negedge mclk_in);
        req_valid_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check({11'h0, pins_out}, 16'h001f);
        check({15'h0, data_pins_oe_n_out}, 16'h0001);
        rst_in = 1'b0;
        $display("test reset done");
        // Boundary addresses, single lanes, empty lane set, back-to-back
        access(1'b1, 17'h00010, 16'h1234, 2'b11);
        access(1'b1, 17'h00000, 16'ha55a, 2'b11);
        access(1'b1, 17'h1ffff, 16'h5aa5, 2'b11);
        access(1'b1, 17'h1ffff, 16'hc3ff, 2'b01);
        access(1'b1, 17'h1ffff, 16'hff3c, 2'b10);
        access(1'b1, 17'h00000, 16'hffff, 2'b00);
        access(1'b0, 17'h1ffff, 16'h0000, 2'b11);
        access(1'b0, 17'h00000, 16'h0000, 2'b01);
        access(1'b0, 17'h00000, 16'h0000, 2'b10);
        access(1'b0, 17'h00010, 16'h0000, 2'b00);
        $display("test corners done");
        // Random mix over a small and a full address set
        repeat (60) begin
            r = $random(seed);
            d = $random(seed);
            a = r[16:0] & (r[17] ? 17'h1ffff : 17'h00007);
            access(r[20], a, d[15:0], r[19:18]);
        end
        $display("test random done");
        give_verdict();
    end
endmodule // tb_top
